// >>> rtl/seg_seq_pkg.sv
// Purpose: Shared constants and types for the segment speed sequencer.
// Assumes: One 100 MHz clock; registers reached as 16-bit words at word addresses.
// Notes:   Digit fields hold one decimal digit per nibble (ones in 3:0, tens in 7:4).
package seg_seq_pkg;

  // Bus and array geometry.
  localparam int           ADDR_W  = 8;
  localparam int           DATA_W  = 16;
  localparam int           NUM_SEG = 15;

  // Register word addresses.
  localparam logic [7:0]   A_RUN_MODE    = 8'h00;
  localparam logic [7:0]   A_CYCLE_LIMIT = 8'h01;
  localparam logic [7:0]   A_RETENTION   = 8'h02;
  localparam logic [7:0]   A_TIME_UNIT   = 8'h03;
  localparam logic [7:0]   A_CONTROL     = 8'h04;
  localparam logic [7:0]   A_CYCLE_MON   = 8'h05;
  localparam logic [7:0]   A_STAGE_MON   = 8'h06;
  localparam logic [7:0]   A_ELAPSED_MON = 8'h07;
  localparam logic [7:0]   A_DIGITAL_SET = 8'h08;
  localparam logic [7:0]   A_SEG_BASE    = 8'h10;
  localparam logic [7:0]   A_SEG_END     = 8'h2E;
  localparam logic [7:0]   A_SPEED_BASE  = 8'h30;
  localparam logic [7:0]   A_SPEED_END   = 8'h3F;

  // Reset values, limits and masks.
  localparam logic [15:0]  RST_CYCLE_LIMIT = 16'h0001;
  localparam logic [15:0]  CYCLE_LIMIT_MIN = 16'h0001;
  localparam logic [15:0]  CYCLE_LIMIT_MAX = 16'h2710;
  localparam logic [15:0]  RUN_MODE_MAX    = 16'h0003;
  localparam logic [15:0]  DURATION_MAX    = 16'hEA60;
  localparam logic [15:0]  RST_DURATION    = 16'h0032;
  localparam logic [15:0]  SETUP_MASK      = 16'h0031;
  localparam logic [15:0]  CYCLE_SAT       = 16'hFFFF;
  localparam logic [3:0]   STAGE_ONE       = 4'h1;

  // Field positions.
  localparam int           DIR_BIT        = 0;
  localparam int           RAMP_LSB       = 4;
  localparam int           STOP_RET_BIT   = 0;
  localparam int           POWER_RET_BIT  = 4;
  localparam int           CTRL_ENABLE    = 0;
  localparam int           CTRL_PANEL_RUN = 1;
  localparam int           CTRL_SRC_LSB   = 2;

  // Run modes and command sources.
  localparam logic [1:0]   MODE_SINGLE     = 2'h0;
  localparam logic [1:0]   MODE_LIMIT_STOP = 2'h1;
  localparam logic [1:0]   MODE_LIMIT_HOLD = 2'h2;
  localparam logic [1:0]   MODE_ENDLESS    = 2'h3;
  localparam logic [1:0]   SRC_PANEL       = 2'h0;
  localparam logic [1:0]   SRC_TERMINAL    = 2'h1;
  localparam logic [1:0]   SRC_COMM        = 2'h2;

  // Time base: durations count in tenths of the selected unit.
  localparam int           CLK_PERIOD_NS      = 10;
  localparam int           TENTH_SECOND_MS    = 100;
  localparam int           TENTH_CYCLES       = TENTH_SECOND_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [5:0]   MINUTE_TENTHS_LAST = 6'h3B;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic [15:0] cycles;
    logic [3:0]  stage;
    logic [15:0] elapsed;
  } progress_s;

  typedef struct packed {
    logic        run;
    logic        reverse;
    logic [1:0]  ramp_set;
    logic [15:0] speed_ref;
  } drive_cmd_s;

endpackage

// >>> rtl/segment_speed_sequencer.sv
// Purpose: Steps a drive through up to fifteen timed segments, or plain multi-speed.
// Assumes: Terminal and command inputs are synchronous to clk.
// Notes:   Outputs are registered and lag the sequencer state by one cycle.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
module segment_speed_sequencer
  import seg_seq_pkg::*;
#(
  parameter int TENTH_CLKS = TENTH_CYCLES
) (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Register port.
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [DATA_W-1:0]  reg_rdata,
  // Terminals and command sources.
  input  wire logic               run_term,
  input  wire logic               fwd_rev_term,
  input  wire logic [3:0]         speed_sel_term,
  input  wire logic               ramp_term_en,
  input  wire logic [1:0]         ramp_term_sel,
  input  wire logic               comm_run,
  // Progress retention across power loss.
  input  wire logic               power_fail,
  input  wire logic               restore_valid,
  input  wire progress_s          restore_data,
  output logic                    save_req,
  output progress_s               save_data,
  // Command to the speed reference path.
  output drive_cmd_s              drive_cmd
);

  // Register file.
  logic [1:0]  run_mode, next_run_mode;
  logic [15:0] cycle_limit, next_cycle_limit;
  logic        stop_ret, next_stop_ret;
  logic        power_ret, next_power_ret;
  logic        time_unit, next_time_unit;
  logic [3:0]  ctrl, next_ctrl;
  logic [15:0] digital_set, next_digital_set;
  logic [15:0] setup [NUM_SEG];
  logic [15:0] next_setup [NUM_SEG];
  logic [15:0] dur [NUM_SEG];
  logic [15:0] next_dur [NUM_SEG];
  logic [15:0] speed [NUM_SEG];
  logic [15:0] next_speed [NUM_SEG];
  logic [15:0] next_rdata;

  // Sequencer state.
  seq_state_e  state, next_state;
  progress_s   prog, next_prog;
  logic        done, next_done;
  // A restored snapshot must survive the first start even without stop retention.
  logic        resumed, next_resumed;
  logic [7:0]  seg_word;
  logic        next_save_req;
  progress_s   next_save_data;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [5:0]  min_cnt, next_min_cnt;
  drive_cmd_s  next_drive_cmd;

  function automatic logic is_seg(input logic [7:0] a);
    return (a >= A_SEG_BASE) && (a < A_SEG_END);
  endfunction

  function automatic logic [7:0] seg_off(input logic [7:0] a);
    return 8'(a - A_SEG_BASE);
  endfunction

  function automatic logic is_speed(input logic [7:0] a);
    return (a >= A_SPEED_BASE) && (a < A_SPEED_END);
  endfunction

  function automatic logic [3:0] speed_idx(input logic [7:0] a);
    return 4'(a - A_SPEED_BASE);
  endfunction

  // The highest segment with a nonzero duration ends the sequence.
  function automatic logic [3:0] last_active();
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < NUM_SEG; i++) begin
      if (dur[i] != 16'h0000) res = 4'(i);
    end
    return res;
  endfunction

  function automatic logic [3:0] first_active();
    logic [3:0] res;
    res = 4'h0;
    for (int i = NUM_SEG - 1; i >= 0; i--) begin
      if (dur[i] != 16'h0000) res = 4'(i);
    end
    return res;
  endfunction

  // Next nonzero segment after cur; wraps to the first one.
  function automatic logic [3:0] next_active(input logic [3:0] cur);
    logic [3:0] res;
    res = first_active();
    for (int i = NUM_SEG - 1; i >= 0; i--) begin
      if ((4'(i) > cur) && (dur[i] != 16'h0000)) res = 4'(i);
    end
    return res;
  endfunction

  logic        any_active;
  logic [3:0]  last_seg;
  logic [3:0]  first_seg;
  logic [15:0] cur_dur;
  logic        run_cmd;
  logic        tick;
  logic        seg_end;
  logic [15:0] cycles_inc;
  progress_s   fresh;

  always_comb begin
    any_active = 1'b0;
    for (int i = 0; i < NUM_SEG; i++) begin
      if (dur[i] != 16'h0000) any_active = 1'b1;
    end
    last_seg  = last_active();
    first_seg = first_active();
    cur_dur   = dur[prog.stage];
    fresh     = '{cycles: 16'h0000, stage: first_seg, elapsed: 16'h0000};
    cycles_inc = (prog.cycles == CYCLE_SAT) ? prog.cycles : 16'(prog.cycles + 16'h0001);
    case (ctrl[CTRL_SRC_LSB +: 2])
      SRC_PANEL:    run_cmd = ctrl[CTRL_PANEL_RUN];
      SRC_TERMINAL: run_cmd = run_term;
      SRC_COMM:     run_cmd = comm_run;
      default:      run_cmd = 1'b0;
    endcase
    // Minutes count sixty tenths-of-seconds per tenth-minute.
    tick = (tick_cnt == 32'(TENTH_CLKS - 1)) &&
           (!time_unit || (min_cnt == MINUTE_TENTHS_LAST));
    seg_end = (cur_dur == 16'h0000) ||
              (tick && (16'(prog.elapsed + 16'h0001) >= cur_dur));
  end

  // Register writes and read data.
  always_comb begin
    next_run_mode    = run_mode;
    next_cycle_limit = cycle_limit;
    next_stop_ret    = stop_ret;
    next_power_ret   = power_ret;
    next_time_unit   = time_unit;
    next_ctrl        = ctrl;
    next_digital_set = digital_set;
    next_setup       = setup;
    next_dur         = dur;
    next_speed       = speed;
    seg_word         = seg_off(reg_addr);
    if (reg_wr) begin
      case (reg_addr)
        A_RUN_MODE: begin
          if (reg_wdata <= RUN_MODE_MAX) next_run_mode = reg_wdata[1:0];
        end
        A_CYCLE_LIMIT: begin
          if (reg_wdata < CYCLE_LIMIT_MIN) next_cycle_limit = CYCLE_LIMIT_MIN;
          else if (reg_wdata > CYCLE_LIMIT_MAX) next_cycle_limit = CYCLE_LIMIT_MAX;
          else next_cycle_limit = reg_wdata;
        end
        A_RETENTION: begin
          next_stop_ret  = reg_wdata[STOP_RET_BIT];
          next_power_ret = reg_wdata[POWER_RET_BIT];
        end
        A_TIME_UNIT:   next_time_unit = reg_wdata[0];
        A_CONTROL:     next_ctrl = reg_wdata[3:0];
        A_DIGITAL_SET: next_digital_set = reg_wdata;
        default: begin
          if (is_seg(reg_addr)) begin
            if (!seg_word[0]) begin
              next_setup[seg_word[4:1]] = reg_wdata & SETUP_MASK;
            end else if (reg_wdata > DURATION_MAX) begin
              next_dur[seg_word[4:1]] = DURATION_MAX;
            end else begin
              next_dur[seg_word[4:1]] = reg_wdata;
            end
          end else if (is_speed(reg_addr)) begin
            next_speed[speed_idx(reg_addr)] = reg_wdata;
          end
        end
      endcase
    end
    next_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        A_RUN_MODE:    next_rdata = {14'h0000, run_mode};
        A_CYCLE_LIMIT: next_rdata = cycle_limit;
        A_RETENTION:   next_rdata = {11'h000, power_ret, 3'h0, stop_ret};
        A_TIME_UNIT:   next_rdata = {15'h0000, time_unit};
        A_CONTROL:     next_rdata = {12'h000, ctrl};
        A_CYCLE_MON:   next_rdata = prog.cycles;
        A_STAGE_MON:   next_rdata = {12'h000, 4'(prog.stage + STAGE_ONE)};
        A_ELAPSED_MON: next_rdata = prog.elapsed;
        A_DIGITAL_SET: next_rdata = digital_set;
        default: begin
          if (is_seg(reg_addr)) begin
            next_rdata = seg_word[0] ? dur[seg_word[4:1]] : setup[seg_word[4:1]];
          end else if (is_speed(reg_addr)) begin
            next_rdata = speed[speed_idx(reg_addr)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_mode    <= MODE_SINGLE;
      cycle_limit <= RST_CYCLE_LIMIT;
      stop_ret    <= 1'b0;
      power_ret   <= 1'b0;
      time_unit   <= 1'b0;
      ctrl        <= 4'h0;
      digital_set <= 16'h0000;
      reg_rdata   <= 16'h0000;
      for (int i = 0; i < NUM_SEG; i++) begin
        setup[i] <= 16'h0000;
        dur[i]   <= RST_DURATION;
        speed[i] <= 16'h0000;
      end
    end else begin
      run_mode    <= next_run_mode;
      cycle_limit <= next_cycle_limit;
      stop_ret    <= next_stop_ret;
      power_ret   <= next_power_ret;
      time_unit   <= next_time_unit;
      ctrl        <= next_ctrl;
      digital_set <= next_digital_set;
      reg_rdata   <= next_rdata;
      setup       <= next_setup;
      dur         <= next_dur;
      speed       <= next_speed;
    end
  end

  // Sequencer, time base and drive command.
  always_comb begin
    next_state     = state;
    next_prog      = prog;
    next_done      = done && run_cmd;
    next_resumed   = resumed;
    next_save_req  = power_fail;
    next_save_data = power_fail ? prog : save_data;
    next_tick_cnt  = tick_cnt;
    next_min_cnt   = min_cnt;
    case (state)
      ST_IDLE: begin
        if (restore_valid && power_ret) begin
          next_prog    = restore_data;
          next_resumed = 1'b1;
          if (restore_data.stage > 4'(NUM_SEG - 1)) next_prog.stage = first_seg;
        end
        if (run_cmd && !done && any_active) begin
          next_state   = ST_RUN;
          next_resumed = 1'b0;
          if (!stop_ret && !resumed && !(restore_valid && power_ret)) begin
            next_prog = fresh;
          end
        end
      end
      ST_RUN: begin
        if (!run_cmd || !any_active) begin
          next_state = ST_IDLE;
        end else if (seg_end) begin
          next_prog.elapsed = 16'h0000;
          if (prog.stage == last_seg) begin
            next_prog.cycles = cycles_inc;
            next_prog.stage  = first_seg;
            case (run_mode)
              MODE_SINGLE: begin
                next_state = ST_IDLE;
                next_prog  = fresh;
                next_done  = 1'b1;
              end
              MODE_LIMIT_STOP: begin
                if (cycles_inc >= cycle_limit) begin
                  next_state = ST_IDLE;
                  next_prog  = fresh;
                  next_done  = 1'b1;
                end
              end
              MODE_LIMIT_HOLD: begin
                if (cycles_inc >= cycle_limit) begin
                  next_state      = ST_HOLD;
                  next_prog.stage = prog.stage;
                end
              end
              default: next_state = ST_RUN;
            endcase
          end else begin
            next_prog.stage = next_active(prog.stage);
          end
        end else if (tick) begin
          next_prog.elapsed = 16'(prog.elapsed + 16'h0001);
        end
      end
      ST_HOLD: begin
        if (!run_cmd) begin
          next_state = ST_IDLE;
          next_prog  = fresh;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // The time base restarts with each segment so every segment gets full tenths.
    if ((state != ST_RUN) || seg_end) begin
      next_tick_cnt = 32'h0000_0000;
      next_min_cnt  = 6'h00;
    end else if (tick_cnt == 32'(TENTH_CLKS - 1)) begin
      next_tick_cnt = 32'h0000_0000;
      next_min_cnt  = (min_cnt == MINUTE_TENTHS_LAST) ? 6'h00 : 6'(min_cnt + 6'h01);
    end else begin
      next_tick_cnt = 32'(tick_cnt + 32'h0000_0001);
    end
    // Drive command.
    next_drive_cmd = '0;
    if (ctrl[CTRL_ENABLE]) begin
      if (state != ST_IDLE) begin
        next_drive_cmd.run       = 1'b1;
        next_drive_cmd.reverse   = setup[prog.stage][DIR_BIT];
        next_drive_cmd.ramp_set  = setup[prog.stage][RAMP_LSB +: 2];
        next_drive_cmd.speed_ref = speed[prog.stage];
      end
    end else begin
      next_drive_cmd.run       = run_cmd;
      next_drive_cmd.reverse   = fwd_rev_term;
      next_drive_cmd.speed_ref = (speed_sel_term == 4'h0) ? digital_set
                                 : speed[4'(speed_sel_term - STAGE_ONE)];
    end
    if (ramp_term_en) next_drive_cmd.ramp_set = ramp_term_sel;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      prog      <= '0;
      done      <= 1'b0;
      resumed   <= 1'b0;
      save_req  <= 1'b0;
      save_data <= '0;
      tick_cnt  <= 32'h0000_0000;
      min_cnt   <= 6'h00;
      drive_cmd <= '0;
    end else begin
      state     <= next_state;
      prog      <= next_prog;
      done      <= next_done;
      resumed   <= next_resumed;
      save_req  <= next_save_req;
      save_data <= next_save_data;
      tick_cnt  <= next_tick_cnt;
      min_cnt   <= next_min_cnt;
      drive_cmd <= next_drive_cmd;
    end
  end

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence last_seg_ends;
    (state == ST_RUN) && run_cmd && any_active && (prog.stage == last_seg) && seg_end;
  endsequence

  a_mode_range: assert property (run_mode <= RUN_MODE_MAX[1:0])
    else $error("run mode out of range");
  a_limit_range: assert property ((cycle_limit >= CYCLE_LIMIT_MIN) &&
                                  (cycle_limit <= CYCLE_LIMIT_MAX))
    else $error("cycle limit out of range");
  a_single_stop: assert property (last_seg_ends and (run_mode == MODE_SINGLE)
                                  |=> (state == ST_IDLE) && done)
    else $error("single pass did not stop");
  a_limit_hold: assert property (last_seg_ends and (run_mode == MODE_LIMIT_HOLD) and
                                 (cycles_inc >= cycle_limit)
                                 |=> (state == ST_HOLD) && (prog.stage == $past(last_seg)))
    else $error("limit hold did not hold last segment");
  a_endless_wrap: assert property (last_seg_ends and (run_mode == MODE_ENDLESS)
                                   |=> (state == ST_RUN) && (prog.stage == $past(first_seg)))
    else $error("endless mode did not wrap");
  a_stop_cmd: assert property ((state != ST_IDLE) && !run_cmd |=> state == ST_IDLE)
    else $error("stop command ignored");
  a_skip_zero: assert property ((state == ST_RUN) && run_cmd && (cur_dur == 16'h0000)
                                |=> (prog.stage != $past(prog.stage)) || (state != ST_RUN))
    else $error("zero duration segment not skipped");
  a_fresh_start: assert property ((state == ST_IDLE) && run_cmd && !done && any_active &&
                                  !stop_ret && !resumed && !(restore_valid && power_ret)
                                  |=> (prog.elapsed == 16'h0000) &&
                                  (prog.cycles == 16'h0000))
    else $error("start without retention did not restart");
  a_resume_kept: assert property ((state == ST_IDLE) && run_cmd && !done && any_active &&
                                  stop_ret && !restore_valid |=> $stable(prog))
    else $error("retained progress lost at start");
  a_speed_follow: assert property (ctrl[CTRL_ENABLE] && (state == ST_RUN) ##1
                                   ctrl[CTRL_ENABLE] |-> drive_cmd.speed_ref ==
                                   $past(speed[prog.stage]))
    else $error("speed reference does not follow segment");

endmodule

// >>> verification/nv_progress_store.sv
// Purpose: Backed-up progress store beside the sequencer (power-loss memory).
// Assumes: Requests are one-cycle pulses synchronous to clk.
// Notes:   Content survives rst_n, as a battery-backed store would.
`timescale 1ns/10ps
module nv_progress_store
  import seg_seq_pkg::*;
(
  // Clock.
  input  wire logic      clk,
  // Save side.
  input  wire logic      save_req,
  input  wire progress_s save_data,
  // Restore side.
  input  wire logic      restore_go,
  output logic           restore_valid,
  output progress_s      restore_data
);
  progress_s kept = '0;

  initial begin
    restore_valid = 1'b0;
    restore_data  = '1;
  end

  always @(posedge clk) begin
    if (save_req) begin
      kept <= save_data;
    end
    restore_valid <= restore_go;
    // Outside the pulse the bus carries junk, so a late sample cannot pass by luck.
    restore_data  <= restore_go ? kept : ~kept;
  end
endmodule

// >>> verification/tb_segment_speed_sequencer.sv
// Purpose: Self-checking bench for the segment speed sequencer.
// Assumes: Short time base, TENTH_CLKS of 4, and a backed-up store beside the block.
// Notes:   Drive command changes are matched in order against queued notes.
`timescale 1ns/10ps
module tb_segment_speed_sequencer
  import seg_seq_pkg::*;
;
  localparam drive_cmd_s CMD_OFF = '0;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [7:0]        reg_addr = '0;
  logic [15:0]       reg_wdata = '0;
  logic [15:0]       reg_rdata;
  logic              reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic              run_term = 1'b0, fwd_rev_term = 1'b0, ramp_term_en = 1'b0;
  logic [3:0]        speed_sel_term = '0, k;
  logic [1:0]        ramp_term_sel = '0, rs;
  logic              comm_run = 1'b0, power_fail = 1'b0, restore_go = 1'b0;
  logic              restore_valid, save_req;
  progress_s         restore_data, save_data;
  drive_cmd_s        drive_cmd, e, last_cmd = '0;
  int                failures = 0, checks_done = 0, cycles = 0, seed = 58326;
  logic [15:0]       setup [1:15], dur [1:15], spd [1:15];
  logic [15:0]       rd_q [$];
  drive_cmd_s        cmd_q [$];
  logic [3:0]        sv_q [$];

  always #5 clk = ~clk;

  segment_speed_sequencer #(.TENTH_CLKS(4)) dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .run_term(run_term), .fwd_rev_term(fwd_rev_term),
    .speed_sel_term(speed_sel_term), .ramp_term_en(ramp_term_en),
    .ramp_term_sel(ramp_term_sel), .comm_run(comm_run), .power_fail(power_fail),
    .restore_valid(restore_valid), .restore_data(restore_data), .save_req(save_req),
    .save_data(save_data), .drive_cmd(drive_cmd));

  nv_progress_store store (.clk(clk), .save_req(save_req), .save_data(save_data),
    .restore_go(restore_go), .restore_valid(restore_valid), .restore_data(restore_data));

  task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Only changes while running matter; idle fields other than run are left open.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rd_d <= reg_rd;
    if (rd_d) begin
      check("reg_rdata", 36'(reg_rdata), 36'(rd_q.pop_front()));
    end
    if (save_req) begin
      check("save_data.stage", 36'(save_data.stage), 36'(sv_q.pop_front()));
    end
    if (drive_cmd !== last_cmd && (drive_cmd.run || last_cmd.run)) begin
      e = (cmd_q.size() > 0) ? cmd_q.pop_front() : last_cmd;
      if (e.run) begin
        check("drive_cmd", 36'(drive_cmd), 36'(e));
      end else begin
        check("drive_cmd.run", 36'(drive_cmd.run), 36'h0);
      end
    end
    last_cmd <= drive_cmd;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  function automatic drive_cmd_s seg(int n);
    return '{1'b1, setup[n][0], setup[n][5:4], spd[n]};
  endfunction

  task automatic wr(logic [7:0] a, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a, logic [15:0] x);
    rd_q.push_back(x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic drain(int lim);
    for (int n = 0; n < lim && cmd_q.size() > 0; n++) begin
      @(posedge clk);
      #1;
    end
    check("cmd_q left", 36'(cmd_q.size()), 36'h0);
    @(posedge clk);
  endtask

  task automatic stop_run;
    cmd_q.push_back(CMD_OFF);
    comm_run <= 1'b0;
    drain(20);
  endtask

  task automatic passes(int n);
    repeat (n) begin
      cmd_q.push_back(seg(1));
      cmd_q.push_back(seg(3));
      cmd_q.push_back(seg(5));
    end
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic prog(logic [15:0] mode, lim, ret, unit);
    wr(A_RUN_MODE, mode);
    wr(A_CYCLE_LIMIT, lim);
    wr(A_RETENTION, ret);
    wr(A_TIME_UNIT, unit);
    wr(A_DIGITAL_SET, 16'h0ABC);
    for (int n = 1; n <= 15; n++) begin
      wr(A_SEG_BASE + 8'(2 * n - 2), setup[n]);
      wr(A_SEG_BASE + 8'(2 * n - 1), dur[n]);
      wr(A_SPEED_BASE + 8'(n - 1), spd[n]);
    end
    wr(A_CONTROL, 16'h0009);
  endtask

  initial begin
    for (int n = 1; n <= 15; n++) begin
      setup[n] = 16'h0000;
      dur[n] = 16'h0000;
      spd[n] = 16'(n) * 16'h0111;
    end
    setup[1] = 16'h0001;
    setup[3] = 16'h0030;
    setup[5] = 16'h0021;
    dur[1] = 16'h0001;
    dur[3] = 16'h0002;
    dur[5] = 16'h0003;
    do_reset();
    rd(A_RUN_MODE, 16'h0000);
    rd(A_CYCLE_LIMIT, 16'h0001);
    rd(A_TIME_UNIT, 16'h0000);
    rd(A_RETENTION, 16'h0000);
    rd(A_SEG_BASE + 8'h01, 16'h0032);
    wr(A_RUN_MODE, 16'h0004);
    rd(A_RUN_MODE, 16'h0000);
    wr(A_CYCLE_LIMIT, 16'h0000);
    rd(A_CYCLE_LIMIT, 16'h0001);
    wr(A_CYCLE_LIMIT, 16'hFFFF);
    rd(A_CYCLE_LIMIT, 16'h2710);
    wr(A_SEG_BASE + 8'h01, 16'hFFFF);
    rd(A_SEG_BASE + 8'h01, 16'hEA60);
    wr(A_SEG_BASE, 16'hFFFF);
    rd(A_SEG_BASE, 16'h0031);
    rd(8'h09, 16'h0000);
    $display("test registers done");
    prog(16'h0000, 16'h0001, 16'h0000, 16'h0000);
    passes(1);
    cmd_q.push_back(CMD_OFF);
    comm_run <= 1'b1;
    drain(200);
    repeat (20) @(posedge clk);
    comm_run <= 1'b0;
    wr(A_RUN_MODE, 16'h0001);
    wr(A_CYCLE_LIMIT, 16'h0002);
    passes(2);
    cmd_q.push_back(CMD_OFF);
    comm_run <= 1'b1;
    drain(300);
    comm_run <= 1'b0;
    wr(A_RUN_MODE, 16'h0002);
    passes(2);
    comm_run <= 1'b1;
    drain(300);
    repeat (40) @(posedge clk);
    stop_run();
    $display("test single and limited modes done");
    wr(A_RUN_MODE, 16'h0003);
    wr(A_RETENTION, 16'h0001);
    passes(3);
    comm_run <= 1'b1;
    drain(400);
    stop_run();
    rd(A_STAGE_MON, 16'h0005);
    rd(A_CYCLE_MON, 16'h0002);
    cmd_q.push_back(seg(5));
    passes(1);
    comm_run <= 1'b1;
    drain(200);
    stop_run();
    wr(A_RETENTION, 16'h0000);
    cmd_q.push_back(seg(1));
    cmd_q.push_back(seg(3));
    comm_run <= 1'b1;
    drain(40);
    stop_run();
    $display("test stop retention done");
    wr(A_RETENTION, 16'h0010);
    cmd_q.push_back(seg(1));
    cmd_q.push_back(seg(3));
    comm_run <= 1'b1;
    drain(40);
    sv_q.push_back(4'h2);
    power_fail <= 1'b1;
    @(posedge clk);
    power_fail <= 1'b0;
    stop_run();
    do_reset();
    prog(16'h0003, 16'h0001, 16'h0010, 16'h0000);
    restore_go <= 1'b1;
    @(posedge clk);
    restore_go <= 1'b0;
    @(posedge clk);
    cmd_q.push_back(seg(3));
    cmd_q.push_back(seg(5));
    comm_run <= 1'b1;
    drain(60);
    stop_run();
    $display("test power retention done");
    wr(A_TIME_UNIT, 16'h0001);
    cmd_q.push_back(seg(1));
    comm_run <= 1'b1;
    repeat (100) @(posedge clk);
    stop_run();
    $display("test minute unit done");
    wr(A_CONTROL, 16'h0004);
    comm_run <= 1'b1;
    ramp_term_en <= 1'b1;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      k = 4'($random(seed));
      rs = 2'($random(seed));
      speed_sel_term <= k;
      ramp_term_sel <= rs;
      fwd_rev_term <= i[0];
      run_term <= 1'b1;
      cmd_q.push_back('{1'b1, i[0], rs, (k == 4'h0) ? 16'h0ABC : spd[k]});
      repeat (4) @(posedge clk);
    end
    cmd_q.push_back(CMD_OFF);
    run_term <= 1'b0;
    drain(20);
    $display("test plain mode done");
    tally_and_finish();
  end
endmodule
